// file: core/fwc_defines.vh
`ifndef FWC_DEFINES_VH
`define FWC_DEFINES_VH
// Register byte offsets
`define FWC_REG_CTRL 12'h000
`define FWC_REG_EMF_CEIL 12'h004
`define FWC_REG_GAINS 12'h008
`define FWC_REG_FILTER 12'h00c
`define FWC_REG_FLOOR 12'h010
`define FWC_REG_OFF_DELAY 12'h014
`define FWC_REG_SETPOINT 12'h018
`define FWC_REG_STATUS 12'h01c
`define FWC_REG_DEMAND 12'h020
`define FWC_REG_FIRE_DELAY 12'h024
`define FWC_REG_LOOP_GAINS 12'h028
// Control bit positions
`define FWC_CTRL_WEAK_EN 0
`define FWC_CTRL_ARM_FB 1
`define FWC_CTRL_ADVANCED 2
`define FWC_CTRL_OFF_MODE 3
`define FWC_CTRL_VOLT_MODE 4
// Reset values; fractions are 16-bit where 16'h4000 is 100 %
`define FWC_FULL 16'h4000
`define FWC_HALF_SHIFT 1
`define FWC_RST_CEIL 16'h4000
`define FWC_RST_FLOOR 16'h0800
`define FWC_RST_GAIN 8'h10
`define FWC_RST_TI 8'h10
`define FWC_RST_FILT 8'h08
`define FWC_RST_DELAY 32'h00000fa0
`define FWC_RST_VOLT_RATIO 16'h3999
// Firing delay margin before the next zero cross, clock ticks
`define FWC_FIRE_MARGIN 16'd2
// Field off states
`define FWC_FS_RUN 2'h0
`define FWC_FS_WAIT 2'h1
`define FWC_FS_QUENCH 2'h2
`define FWC_FS_STANDBY 2'h3
`endif

// file: core/fwc_field_weakening.v
`timescale 1ns/1ps
`include "fwc_defines.vh"
//////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Above base speed, hold back-EMF at ceiling
// [RULE2] Armature volts feedback clamps demand at 100%
// [RULE3] Error is back-EMF excess over ceiling
// [RULE4] Gain-limited PI with dc gain, integral time
// [RULE5] Lag/lead filter on back-EMF measurement
// [RULE6] Software keeps filter lag:lead at most 3:1
// [RULE7] Software keeps controller lag:lead above 10
// [RULE8] Advanced mode adds speed feedforward term
// [RULE9] Advanced mode raises EMF gain below full speed
// [RULE10] Advanced mode raises speed gain below full field
// [RULE11] Filter works in advanced and standard mode
// [RULE12] Quench delay then field off or half
// [RULE13] Quench acts same in current, voltage modes
// [RULE14] Firing delay from zero cross, once per half cycle
// [RULE15] Demand clamped between floor and 100%
module fwc_field_weakening #(
    parameter DW = 16, // Fraction width, 16'h4000 = 100 %
    parameter HALF_CYCLE_TICKS = 16'd16000, // Clock ticks per mains half cycle
    parameter [31:0] OFF_DELAY_DEFAULT = `FWC_RST_DELAY // Quench delay in samples
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sample_strobe, // Control loop sample tick, same domain
    input wire [DW-1:0] emf_meas, // Measured back-EMF
    input wire [DW-1:0] speed_fbk, // Speed feedback magnitude
    input wire [DW-1:0] field_current_fbk, // Measured field current
    input wire arm_quenched, // Armature current quenched
    input wire zero_cross_pin, // Mains zero cross, asynchronous
    output reg [DW-1:0] field_demand, // Field current demand
    output reg [DW-1:0] speed_gain_scale, // Speed loop gain multiplier
    output reg field_fire // At most one pulse per half cycle, none while the demand is zero
);

//////////////////////////////////////////////////////////////////////
// Fixed-point helpers
function [DW-1:0] fmul; // Fraction multiply, 100 % = 2^14
    input [DW-1:0] a;
    input [DW-1:0] b;
    reg [2*DW-1:0] p;
    begin
        p = a * b;
        fmul = p[DW+13:14];
    end
endfunction

function [DW-1:0] fclamp; // Saturate signed value to range
    input signed [DW+1:0] v;
    input [DW-1:0] lo;
    input [DW-1:0] hi;
    begin
        if (v < $signed({2'b00, lo})) begin
            fclamp = lo;
        end else if (v > $signed({2'b00, hi})) begin
            fclamp = hi;
        end else begin
            fclamp = v[DW-1:0];
        end
    end
endfunction

function [DW-1:0] fgain; // Full over a fraction, saturated gain
    input [DW-1:0] d;
    reg [DW-1:0] dl;
    reg [2*DW-1:0] q;
    begin
        // Quarter floor keeps the quotient at x4 or below
        dl = (d < (`FWC_FULL >> 2)) ? (`FWC_FULL >> 2) : d;
        q = {`FWC_FULL, 14'h0} / dl;
        // x4 itself does not fit the output, saturate
        fgain = (q > {{DW{1'b0}}, {DW{1'b1}}}) ? {DW{1'b1}} : q[DW-1:0];
    end
endfunction

//////////////////////////////////////////////////////////////////////
// Registers
reg [4:0] ctrl; // Mode bits
reg [DW-1:0] emf_ceiling; // Back-EMF ceiling
reg [7:0] emf_gain; // Dc gain, 16 = unity
reg [7:0] emf_ti; // Integral time, shift of 1/ti
reg [7:0] emf_filter_lead_time; // Filter lead, samples
reg [7:0] emf_filter_lag_time; // Filter lag, samples
reg [DW-1:0] field_current_floor; // Lowest weakened demand
reg [31:0] field_off_delay; // Quench delay, samples
reg [DW-1:0] setpoint; // Field setpoint
reg [DW-1:0] volt_ratio; // Open loop voltage ratio
wire weakening_enable = ctrl[`FWC_CTRL_WEAK_EN];
wire arm_volts_fbk = ctrl[`FWC_CTRL_ARM_FB];
wire advanced = ctrl[`FWC_CTRL_ADVANCED];
wire field_off_behaviour = ctrl[`FWC_CTRL_OFF_MODE];
wire volt_mode = ctrl[`FWC_CTRL_VOLT_MODE];

// Loop state
reg [DW-1:0] emf_filt; // Lag state of the filter
reg [DW-1:0] emf_prev; // Previous raw sample
reg signed [DW+1:0] integ; // PI integrator, a reduction amount
reg [DW-1:0] weak_demand; // Weakened demand fraction
reg [1:0] fs_state; // Field off state
reg [31:0] off_count; // Quench delay counter
reg [DW-1:0] fire_delay; // Firing delay, clock ticks
reg [15:0] half_count; // Ticks since zero cross
reg [2:0] zc_sync; // Zero cross synchroniser
reg zc_level; // Debounced zero cross level
reg fire_done; // Firing already issued this half cycle

//////////////////////////////////////////////////////////////////////
// APB write and read
wire apb_acc = psel && penable && !pready;
wire unmapped = (paddr > `FWC_REG_LOOP_GAINS) || (paddr[1:0] != 2'b00);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl <= 5'h00;
        emf_ceiling <= `FWC_RST_CEIL;
        emf_gain <= `FWC_RST_GAIN;
        emf_ti <= `FWC_RST_TI;
        emf_filter_lead_time <= `FWC_RST_FILT;
        emf_filter_lag_time <= `FWC_RST_FILT;
        field_current_floor <= `FWC_RST_FLOOR;
        field_off_delay <= OFF_DELAY_DEFAULT;
        setpoint <= `FWC_FULL;
        volt_ratio <= `FWC_RST_VOLT_RATIO;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (clk_en) begin
        pready <= apb_acc; // One wait state
        pslverr <= apb_acc && unmapped;
        prdata <= 32'h00000000;
        if (apb_acc && pwrite && !unmapped) begin
            case (paddr)
                `FWC_REG_CTRL: ctrl <= pwdata[4:0];
                `FWC_REG_EMF_CEIL: emf_ceiling <= pwdata[DW-1:0];
                `FWC_REG_GAINS: begin
                    emf_gain <= pwdata[7:0];
                    emf_ti <= pwdata[15:8];
                end
                `FWC_REG_FILTER: begin
                    emf_filter_lead_time <= pwdata[7:0];
                    emf_filter_lag_time <= pwdata[15:8];
                end
                `FWC_REG_FLOOR: field_current_floor <= pwdata[DW-1:0];
                `FWC_REG_OFF_DELAY: field_off_delay <= pwdata;
                `FWC_REG_SETPOINT: begin
                    setpoint <= pwdata[DW-1:0];
                    volt_ratio <= pwdata[31:16];
                end
                default: ;
            endcase
        end else if (apb_acc && !pwrite && !unmapped) begin
            case (paddr)
                `FWC_REG_CTRL: prdata <= {27'h0, ctrl};
                `FWC_REG_EMF_CEIL: prdata <= {16'h0, emf_ceiling};
                `FWC_REG_GAINS: prdata <= {16'h0, emf_ti, emf_gain};
                `FWC_REG_FILTER: prdata <= {16'h0, emf_filter_lag_time, emf_filter_lead_time};
                `FWC_REG_FLOOR: prdata <= {16'h0, field_current_floor};
                `FWC_REG_OFF_DELAY: prdata <= field_off_delay;
                `FWC_REG_SETPOINT: prdata <= {volt_ratio, setpoint};
                `FWC_REG_STATUS: prdata <= {14'h0, fs_state, emf_filt};
                `FWC_REG_DEMAND: prdata <= {weak_demand, field_demand};
                `FWC_REG_FIRE_DELAY: prdata <= {field_current_fbk, fire_delay};
                `FWC_REG_LOOP_GAINS: prdata <= {16'h0, speed_gain_scale};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
end

//////////////////////////////////////////////////////////////////////
// Back-EMF lag/lead filter, active in both modes
// y += (x - y)/lag + (x - x_prev)*(lead - 1)/lag; lead equal lag is neutral
wire signed [DW+1:0] emf_step = $signed({2'b00, emf_meas}) - $signed({2'b00, emf_filt});
wire signed [DW+1:0] emf_diff = $signed({2'b00, emf_meas}) - $signed({2'b00, emf_prev});
wire [7:0] lag_nz = (emf_filter_lag_time == 8'h00) ? 8'h01 : emf_filter_lag_time;
wire signed [DW+9:0] lead_term = emf_diff * $signed({1'b0, emf_filter_lead_time});
wire signed [DW+9:0] emf_sum = $signed({2'b00, emf_filt}) + emf_step / $signed({1'b0, lag_nz})
    + (lead_term - emf_diff) / $signed({1'b0, lag_nz}); // see [RULE5] see [RULE11]
// Saturate so a large lead cannot wrap the filter state
wire [DW-1:0] emf_next = (emf_sum < 0) ? {DW{1'b0}}
    : (emf_sum > $signed({10'h0, {DW{1'b1}}})) ? {DW{1'b1}} : emf_sum[DW-1:0];

// Control error and PI
wire signed [DW+1:0] emf_err = $signed({2'b00, emf_filt}) - $signed({2'b00, emf_ceiling}); // see [RULE3]
// Adaptive emf gain: scale by full / speed, capped at x4
wire [DW-1:0] emf_adapt = advanced ? fgain(speed_fbk) : `FWC_FULL; // see [RULE9]
// Full-width product, then scaled back; a narrow product would overflow
wire signed [2*DW+3:0] err_prod = emf_err * $signed({1'b0, emf_adapt});
wire signed [DW+1:0] err_scaled = err_prod[DW+15:14];
wire signed [DW+9:0] p_term = (err_scaled * $signed({1'b0, emf_gain})) >>> 4; // see [RULE4]
wire signed [DW+1:0] i_next = integ + (err_scaled >>> emf_ti[3:0]); // see [RULE4]
// Feedforward: base speed is ceiling-scaled full field speed
wire [DW-1:0] base_speed = fmul(emf_ceiling, `FWC_FULL);
wire [2*DW-1:0] ff_ratio = {base_speed, 14'h0} / ((speed_fbk == 0) ? 16'h0001 : speed_fbk);
wire [DW-1:0] ff_red = (advanced && speed_fbk > base_speed) ? (`FWC_FULL - ff_ratio[DW-1:0]) : {DW{1'b0}}; // see [RULE8]
wire signed [DW+1:0] red_total = p_term[DW+1:0] + i_next + $signed({2'b00, ff_red});
wire signed [DW+1:0] demand_raw = $signed({2'b00, `FWC_FULL}) - red_total; // see [RULE1]
wire [DW-1:0] next_weak = (!weakening_enable || arm_volts_fbk) ? `FWC_FULL // see [RULE2]
    : fclamp(demand_raw, field_current_floor, `FWC_FULL); // see [RULE15]

//////////////////////////////////////////////////////////////////////
// Sampled loop update
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        emf_filt <= {DW{1'b0}};
        emf_prev <= {DW{1'b0}};
        integ <= {(DW+2){1'b0}};
        weak_demand <= `FWC_FULL;
        speed_gain_scale <= `FWC_FULL;
    end else if (clk_en && sample_strobe) begin
        emf_filt <= emf_next;
        emf_prev <= emf_meas;
        weak_demand <= next_weak;
        // Integrator holds in range, gain limited by clamp
        if (!weakening_enable || arm_volts_fbk) begin
            integ <= {(DW+2){1'b0}};
        end else if (i_next < 0) begin
            integ <= {(DW+2){1'b0}};
        end else if (i_next > $signed({2'b00, `FWC_FULL})) begin
            integ <= $signed({2'b00, `FWC_FULL});
        end else begin
            integ <= i_next;
        end
        // Speed gain raised as field falls, capped at x4
        if (advanced) begin
            speed_gain_scale <= fgain(weak_demand); // see [RULE10]
        end else begin
            speed_gain_scale <= `FWC_FULL;
        end
    end
end

//////////////////////////////////////////////////////////////////////
// Standby field sequencer
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fs_state <= `FWC_FS_RUN;
        off_count <= 32'h0;
    end else if (clk_en && sample_strobe) begin
        case (fs_state)
            `FWC_FS_RUN: begin
                off_count <= 32'h0;
                if (arm_quenched) begin
                    fs_state <= `FWC_FS_WAIT; // see [RULE12]
                end
            end
            `FWC_FS_WAIT: begin
                if (!arm_quenched) begin
                    fs_state <= `FWC_FS_RUN;
                end else if (off_count + 32'h1 >= field_off_delay) begin
                    fs_state <= field_off_behaviour ? `FWC_FS_STANDBY : `FWC_FS_QUENCH; // see [RULE12]
                end else begin
                    off_count <= off_count + 32'h1;
                end
            end
            default: begin
                if (!arm_quenched) begin
                    fs_state <= `FWC_FS_RUN;
                end
            end
        endcase
    end
end

// Final demand, same quench path for current and voltage control
wire [DW-1:0] base_dmd = volt_mode ? volt_ratio : fmul(setpoint, weak_demand);
wire [DW-1:0] next_dmd = (fs_state == `FWC_FS_QUENCH) ? {DW{1'b0}}
    : (fs_state == `FWC_FS_STANDBY) ? (base_dmd >> `FWC_HALF_SHIFT) : base_dmd; // see [RULE13]

//////////////////////////////////////////////////////////////////////
// Zero cross synchroniser, firing delay and firing pulse
wire [DW-1:0] fire_err = (next_dmd > field_current_fbk) ? (next_dmd - field_current_fbk) : 16'h0;
wire [2*DW-1:0] delay_w = (`FWC_FULL - ((fire_err > `FWC_FULL) ? `FWC_FULL : fire_err)) * HALF_CYCLE_TICKS;
wire [DW-1:0] fire_cap = HALF_CYCLE_TICKS - `FWC_FIRE_MARGIN; // Latest delay the count still reaches
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        zc_sync <= 3'h0;
        zc_level <= 1'b0;
        half_count <= 16'h0;
        fire_delay <= {DW{1'b0}};
        field_demand <= {DW{1'b0}};
        field_fire <= 1'b0;
        fire_done <= 1'b0;
    end else if (clk_en) begin
        zc_sync <= {zc_sync[1:0], zero_cross_pin};
        field_demand <= next_dmd;
        field_fire <= 1'b0;
        // Capped so a small error still fires inside the half cycle
        fire_delay <= (delay_w[DW+13:14] > fire_cap) ? fire_cap : delay_w[DW+13:14]; // see [RULE14]
        if (zc_sync[1] == zc_sync[2] && zc_sync[2] != zc_level) begin
            zc_level <= zc_sync[2];
            half_count <= 16'h0; // Each edge starts a half cycle
            fire_done <= 1'b0; // Rearm for the new half cycle
        end else begin
            // Count saturates if the mains stops
            if (half_count != 16'hffff) begin
                half_count <= half_count + 16'h1;
            end
            // One firing per half cycle, even if the delay moves
            if (!fire_done && half_count >= fire_delay && next_dmd != {DW{1'b0}}) begin
                field_fire <= 1'b1; // see [RULE14]
                fire_done <= 1'b1;
            end
        end
    end
end

endmodule // fwc_field_weakening

// file: testbench/fwc_field_weakening_sva.sv
`timescale 1ns/1ps
// Port-level checks of the weakening block
module fwc_field_weakening_sva #(
    parameter DW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [DW-1:0] field_demand,
    input wire field_fire
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_PULSE: assert property (pready && clk_en |=> !pready) else $error("pready held too long");
    AST_READY_ANSWER: assert property (psel && penable && !pready && clk_en |=> pready) else $error("no answer");
    AST_READY_CAUSE: assert property ($rose(pready) |-> $past(psel && penable)) else $error("stray pready");
    AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_ERR_RANGE: assert property (psel && penable && !pready && clk_en && paddr > 12'h028 |=> pslverr)
        else $error("unmapped access not refused");
    AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
    AST_FIRE_PULSE: assert property (field_fire && clk_en |=> !field_fire) else $error("fire pulse too long");
    AST_DEMAND_CAP: assert property (field_demand <= 16'h4000) else $error("demand above full");
    AST_FREEZE: assert property (!clk_en |=> $stable(field_demand) && $stable(field_fire)) else $error("moved frozen");
endmodule // fwc_field_weakening_sva
bind fwc_field_weakening fwc_field_weakening_sva #(.DW(DW)) fwc_field_weakening_sva_i (.pclk, .presetn, .clk_en,
    .psel, .penable, .paddr, .prdata, .pready, .pslverr, .field_demand, .field_fire);

// file: testbench/fwc_bridge_model.sv
`timescale 1ns/1ps
// Mains and field bridge stand-in
module fwc_bridge_model #(
    parameter HALF = 64 // Clock ticks per mains half cycle
) (
    input wire pclk,
    input wire presetn,
    input wire [15:0] field_demand,
    input wire field_fire,
    output reg zero_cross_pin,
    output reg [15:0] field_current_fbk
);
    reg [15:0] tick; // Half-cycle timer
    // Mains zero-cross level flips every half cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 16'h0000;
            zero_cross_pin <= 1'b0;
        end else if (tick == HALF - 1) begin
            tick <= 16'h0000;
            zero_cross_pin <= ~zero_cross_pin;
        end else begin
            tick <= tick + 16'h0001;
        end
    end
    // Field current moves halfway to demand at each firing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            field_current_fbk <= 16'h0000;
        end else if (field_fire) begin
            field_current_fbk <= (field_current_fbk >> 1) + (field_demand >> 1);
        end
    end
endmodule // fwc_bridge_model

// file: testbench/field_weakening_controller_tb_top.sv
`timescale 1ns/1ps
`include "fwc_defines.vh"
module field_weakening_controller_tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg clk_en = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_strobe = 1'b0, arm_quenched = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [15:0] emf_meas = 16'h0000, speed_fbk = 16'h0000;
    reg rd_err;
    wire [31:0] prdata;
    wire pready, pslverr, zero_cross_pin, field_fire;
    wire [15:0] field_demand, speed_gain_scale, field_current_fbk;
    integer n_mismatch = 0, n_checks = 0, cyc = 0, i, k;
    initial forever #12.5 pclk = ~pclk;
    fwc_field_weakening #(.HALF_CYCLE_TICKS(16'd64)) fwc_field_weakening_i (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_strobe, .emf_meas, .speed_fbk,
        .field_current_fbk, .arm_quenched, .zero_cross_pin, .field_demand, .speed_gain_scale, .field_fire);
    fwc_bridge_model #(.HALF(64)) fwc_bridge_model_i (.pclk, .presetn, .field_demand, .field_fire,
        .zero_cross_pin, .field_current_fbk);
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task end_sim;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Loop samples with settling gaps
    task strobes(input integer n);
        repeat (n) begin
            @(posedge pclk);
            sample_strobe <= 1'b1;
            @(posedge pclk);
            sample_strobe <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `FWC_REG_EMF_CEIL, 0);
        chk(rd, 32'h4000);
        apb(0, `FWC_REG_FLOOR, 0);
        chk(rd, 32'h0800);
        apb(0, `FWC_REG_GAINS, 0);
        chk(rd, {16'h0, `FWC_RST_TI, `FWC_RST_GAIN});
        apb(0, 12'h02c, 0);
        chk({31'h0, rd_err}, 32'h1);
        chk(rd, 32'h0);
        apb(1, `FWC_REG_FILTER, 32'h0808);
        emf_meas <= 16'h3000;
        strobes(8);
        apb(0, `FWC_REG_STATUS, 0);
        chk(rd[17:0], 18'h03000);
        emf_meas <= 16'h6000;
        speed_fbk <= 16'h6000;
        apb(1, `FWC_REG_CTRL, 32'h3);
        strobes(10);
        chk(field_demand, 16'h4000);
        apb(1, `FWC_REG_CTRL, 32'h1);
        strobes(20);
        clk_en <= 1'b0;
        repeat (6) @(posedge pclk);
        clk_en <= 1'b1;
        chk(field_demand < 16'h4000 && field_demand >= 16'h0800, 1);
        apb(1, `FWC_REG_FLOOR, 32'h3800);
        strobes(20);
        chk(field_demand >= 16'h3800, 1);
        apb(1, `FWC_REG_FLOOR, 32'h0800);
        apb(1, `FWC_REG_CTRL, 32'h5);
        strobes(20);
        chk(field_demand < 16'h4000 && speed_gain_scale > 16'h4000, 1);
        apb(0, `FWC_REG_STATUS, 0);
        chk(rd[15:0], 16'h6000);
        k = 0;
        repeat (640) begin
            @(posedge pclk);
            if (field_fire === 1'b1) k = k + 1;
        end
        chk(k >= 9 && k <= 11, 1);
        apb(1, `FWC_REG_OFF_DELAY, 32'h3);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, `FWC_REG_CTRL, {27'h0, i[1], i[0], 3'h0});
            strobes(2);
            arm_quenched <= 1'b1;
            strobes(1);
            apb(0, `FWC_REG_STATUS, 0);
            chk(rd[17:16], `FWC_FS_WAIT);
            strobes(5);
            apb(0, `FWC_REG_STATUS, 0);
            chk(rd[17:16], i[0] ? `FWC_FS_STANDBY : `FWC_FS_QUENCH);
            if (!i[0]) chk(field_demand, 16'h0000);
            if (i == 1) chk(field_demand, 16'h2000);
            if (i == 3) chk(field_demand, `FWC_RST_VOLT_RATIO >> `FWC_HALF_SHIFT);
            arm_quenched <= 1'b0;
        end
        end_sim;
    end
endmodule // field_weakening_controller_tb_top
